// File: src/spc_pkg.sv
package spc_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int DIM_W   = 16;
  localparam int BYTE_W  = 32;
  localparam int BPT_W   = 5;

  // ------------------------------------------------------------------
  // padding constants
  // ------------------------------------------------------------------
  localparam logic [DIM_W-1:0]  BUF_ELEM_UNIT   = 16'h0100;
  localparam logic [BYTE_W-1:0] L1_TAIL_BYTES   = 32'h0000_0010;
  localparam logic [DIM_W-1:0]  CUBE_EXTRA_ROWS = 16'h0002;
  localparam logic [DIM_W-1:0]  BC_PAD_J        = 16'h0008;
  localparam logic [DIM_W-1:0]  BC_LAYOUT_J     = 16'h0004;
  localparam logic [DIM_W-1:0]  FIELD_ROW_UNIT  = 16'h0004;
  localparam logic [DIM_W-1:0]  ONE_ROW         = 16'h0001;
  localparam logic [BPT_W-1:0]  BPT_96          = 5'h0C;
  localparam logic [BPT_W-1:0]  BPT_48          = 5'h06;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SPC_SAMPLED,
    SPC_BUFFER,
    SPC_RENDER
  } spc_kind_e;

  typedef struct packed {
    spc_kind_e         kind;
    logic [DIM_W-1:0]  width;
    logic [DIM_W-1:0]  height;
    logic [DIM_W-1:0]  align_i;
    logic [DIM_W-1:0]  align_j;
    logic [BPT_W-1:0]  bytes_per_texel;
    logic              is_cube;
    logic              is_compressed;
    logic              is_yuv;
    logic              field_mode;
  } spc_req_s;

  typedef struct packed {
    logic [DIM_W-1:0]  pad_width;
    logic [DIM_W-1:0]  pad_height;
    logic [DIM_W-1:0]  layout_j;
    logic [BYTE_W-1:0] tail_bytes;
    logic [BYTE_W-1:0] total_bytes;
  } spc_rsp_s;

  typedef struct packed {
    logic              valid;
    logic              mapped;
    logic              in_surface;
    logic [DIM_W-1:0]  x;
    logic [DIM_W-1:0]  y;
  } spc_elem_s;

endpackage : spc_pkg

// File: src/spc_surface_padding.sv
`timescale 1ns/1ps
// How it works
// [R1] sampled texels outside the surface are zeroed, never reach results
// [R2] sampling fetch touching an unmapped page raises a translation error
// [R3] allocator maps every page touched by any surface cache line
// [R4] sampled width and height round up to alignment units i and j
// [R5] padded texel extent is converted to bytes with bytes per texel
// [R6] buffers pad to 256 elements plus 16 tail bytes
// [R7] cube surfaces add two rows below
// [R8] compressed formats pad height with j of 8
// [R9] compressed mip layout and slice pitch still use j of 4
// [R10] yuv, 96 and 48 bpt add one row plus 16 bytes
// [R11] data port drops out-of-surface pixels from the reply
// [R12] data port request on an unmapped page raises a translation error
// [R13] render or media surface with odd rows gets one more row
// [R14] field mode pads render height to a multiple of 4
// [R15] all matching padding applied together, padded sizes output
module spc_surface_padding
  import spc_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      reset,
  input  wire logic      req_valid,
  input  wire spc_req_s  req,
  output logic           rsp_valid,
  output spc_rsp_s       rsp,
  input  wire spc_elem_s samp_elem,
  input  wire logic [31:0] samp_data,
  output logic           samp_out_valid,
  output logic [31:0]    samp_out_data,
  output logic           samp_xlate_err,
  input  wire spc_elem_s port_elem,
  input  wire logic [31:0] port_data,
  output logic           port_out_valid,
  output logic [31:0]    port_out_data,
  output logic           port_xlate_err
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [DIM_W-1:0] round_up(
    input logic [DIM_W-1:0] v,
    input logic [DIM_W-1:0] unit
  );
    logic [DIM_W-1:0] rem;
    rem = (unit == '0) ? '0 : v % unit;
    if (rem == '0) begin
      return v;
    end
    return DIM_W'(v + unit - rem);
  endfunction : round_up

  // ------------------------------------------------------------------
  // size calculation
  // ------------------------------------------------------------------
  spc_rsp_s         rsp_next;
  logic [DIM_W-1:0] w_c;
  logic [DIM_W-1:0] h_c;
  logic [DIM_W-1:0] jp_c;
  logic [BYTE_W-1:0] tail_c;
  logic             wide_fmt;

  always_comb begin
    w_c      = req.width;
    h_c      = req.height;
    tail_c   = '0;
    wide_fmt = req.is_yuv || (req.bytes_per_texel == BPT_96) ||
               (req.bytes_per_texel == BPT_48);
    jp_c     = req.is_compressed ? BC_PAD_J : req.align_j; // [R8]
    unique case (req.kind)
      SPC_SAMPLED: begin
        w_c = round_up(req.width, req.align_i); // [R4]
        h_c = round_up(req.height, jp_c); // [R4] [R8]
        if (req.is_cube) begin
          h_c = DIM_W'(h_c + CUBE_EXTRA_ROWS); // [R7]
        end
        if (wide_fmt) begin
          h_c    = DIM_W'(h_c + ONE_ROW); // [R10]
          tail_c = L1_TAIL_BYTES; // [R10]
        end
      end
      SPC_BUFFER: begin
        w_c    = round_up(req.width, BUF_ELEM_UNIT); // [R6]
        h_c    = ONE_ROW;
        tail_c = L1_TAIL_BYTES; // [R6]
      end
      SPC_RENDER: begin
        if (req.height[0]) begin
          h_c = DIM_W'(h_c + ONE_ROW); // [R13]
        end
        if (req.field_mode) begin
          h_c = round_up(h_c, FIELD_ROW_UNIT); // [R14]
        end
      end
      default: begin
        w_c = req.width;
      end
    endcase
    rsp_next.pad_width   = w_c; // [R15]
    rsp_next.pad_height  = h_c;
    rsp_next.layout_j    = req.is_compressed ? BC_LAYOUT_J
                                             : req.align_j; // [R9]
    rsp_next.tail_bytes  = tail_c;
    rsp_next.total_bytes = BYTE_W'(BYTE_W'(w_c) * BYTE_W'(h_c) *
                           BYTE_W'(req.bytes_per_texel)) + tail_c; // [R5]
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rsp       <= '0;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= req_valid;
      if (req_valid) begin
        rsp <= rsp_next;
      end
    end
  end

  // ------------------------------------------------------------------
  // sampling path filter
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      samp_out_valid <= 1'b0;
      samp_out_data  <= '0;
      samp_xlate_err <= 1'b0;
    end else begin
      samp_out_valid <= samp_elem.valid && samp_elem.mapped;
      samp_xlate_err <= samp_elem.valid && !samp_elem.mapped; // [R2]
      samp_out_data  <= samp_elem.in_surface ? samp_data : '0; // [R1]
    end
  end

  // ------------------------------------------------------------------
  // data port filter
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      port_out_valid <= 1'b0;
      port_out_data  <= '0;
      port_xlate_err <= 1'b0;
    end else begin
      port_out_valid <= port_elem.valid && port_elem.mapped &&
                        port_elem.in_surface; // [R11]
      port_xlate_err <= port_elem.valid && !port_elem.mapped; // [R12]
      port_out_data  <= port_data;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  rsp_follows_a: assert property (req_valid |=> rsp_valid) // [R15]
    else $error("answer missing after request");
  buf_tail_a: assert property (req_valid && req.kind == SPC_BUFFER
    |=> rsp.tail_bytes == L1_TAIL_BYTES) // [R6]
    else $error("buffer tail bytes wrong");
  buf_mult_a: assert property (req_valid && req.kind == SPC_BUFFER
    |=> (rsp.pad_width % BUF_ELEM_UNIT) == '0) // [R6]
    else $error("buffer not padded to element unit");
  bc_layout_a: assert property (req_valid && req.is_compressed
    |=> rsp.layout_j == BC_LAYOUT_J) // [R9]
    else $error("compressed layout unit wrong");
  bc_pad_a: assert property (req_valid && req.is_compressed &&
    req.kind == SPC_SAMPLED && !req.is_cube && !wide_fmt
    |=> rsp.pad_height[2:0] == 3'h0) // [R8]
    else $error("compressed height not multiple of 8");
  field_mult_a: assert property (req_valid && req.kind == SPC_RENDER &&
    req.field_mode |=> rsp.pad_height[1:0] == 2'h0) // [R14]
    else $error("field mode height not multiple of 4");
  odd_row_a: assert property (req_valid && req.kind == SPC_RENDER &&
    !req.field_mode |=> !rsp.pad_height[0]) // [R13]
    else $error("render height left odd");
  wide_tail_a: assert property (req_valid && req.kind == SPC_SAMPLED &&
    wide_fmt |=> rsp.tail_bytes == L1_TAIL_BYTES) // [R10]
    else $error("wide format tail missing");
  samp_err_a: assert property (samp_elem.valid && !samp_elem.mapped
    |=> samp_xlate_err && !samp_out_valid) // [R2]
    else $error("sampling translation error missing");
  samp_zero_a: assert property (!samp_elem.in_surface
    |=> samp_out_data == '0) // [R1]
    else $error("outside texel leaked");
  port_drop_a: assert property (!port_elem.in_surface
    |=> !port_out_valid) // [R11]
    else $error("outside pixel returned");
  port_err_a: assert property (port_elem.valid && !port_elem.mapped
    |=> port_xlate_err) // [R12]
    else $error("port translation error missing");
  rsp_hold_a: assert property (!req_valid |=> $stable(rsp)) // [R15]
    else $error("answer changed without request");
  buf_height_a: assert property (req_valid && req.kind == SPC_BUFFER
    |=> rsp.pad_height == ONE_ROW) // [R6]
    else $error("buffer height not one row");
  render_width_a: assert property (req_valid && req.kind == SPC_RENDER
    |=> rsp.pad_width == $past(req.width)) // [R13]
    else $error("render width changed");
  samp_data_a: assert property (samp_elem.in_surface
    |=> samp_out_data == $past(samp_data)) // [R1]
    else $error("inside texel lost");
  samp_ok_a: assert property (samp_elem.valid && samp_elem.mapped
    |=> samp_out_valid && !samp_xlate_err) // [R2]
    else $error("mapped texel not delivered");
  samp_idle_a: assert property (!samp_elem.valid
    |=> !samp_out_valid && !samp_xlate_err) // [R2]
    else $error("sampling output without element");
  port_ok_a: assert property (port_elem.valid && port_elem.mapped
    |=> !port_xlate_err) // [R12]
    else $error("port error on mapped page");
  port_data_a: assert property (port_elem.valid && port_elem.mapped &&
    port_elem.in_surface |=> port_out_data == $past(port_data)) // [R11]
    else $error("returned pixel data wrong");

  cube_c: cover property (req_valid && req.is_cube);
  buf_c: cover property (req_valid && req.kind == SPC_BUFFER);
  field_c: cover property (req_valid && req.field_mode);
  err_c: cover property (samp_xlate_err);
  bc_c: cover property (req_valid && req.is_compressed &&
    req.kind == SPC_SAMPLED);

endmodule : spc_surface_padding

// File: verif/spc_alloc_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// allocator: backs only the pages that hold the padded extent
// ------------------------------------------------------------------
module spc_alloc_model
  import spc_pkg::*;
#(
  parameter int PAGE_BYTES = 4096
)
(
  input  wire spc_rsp_s          rsp,
  input  wire logic [BYTE_W-1:0] offset,
  output logic                   mapped
);
  // nothing is mapped before the first padded size is known
  assign mapped = (rsp.total_bytes != 0) &&
    (offset / PAGE_BYTES <= (rsp.total_bytes - 1) / PAGE_BYTES);
endmodule : spc_alloc_model

// File: verif/surface_padding_calc_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module surface_padding_calc_test;
  import spc_pkg::*;
  logic        ref_clk, reset, req_valid, rsp_valid, mapped, pv;
  logic        samp_out_valid, samp_xlate_err, port_out_valid, port_xlate_err;
  logic [31:0] samp_data, port_data, samp_out_data, port_out_data;
  logic [31:0] offset, psd, ppd;
  spc_req_s    req, pr;
  spc_rsp_s    rsp, ex;
  spc_elem_s   samp_elem, port_elem, ps, pp;
  int          num_errors, compares, seed;

  spc_surface_padding u_dut (.ref_clk(ref_clk), .reset(reset),
    .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
    .samp_elem(samp_elem), .samp_data(samp_data),
    .samp_out_valid(samp_out_valid), .samp_out_data(samp_out_data),
    .samp_xlate_err(samp_xlate_err), .port_elem(port_elem),
    .port_data(port_data), .port_out_valid(port_out_valid),
    .port_out_data(port_out_data), .port_xlate_err(port_xlate_err));
  spc_alloc_model u_alloc (.rsp(rsp), .offset(offset), .mapped(mapped));

  function automatic logic [15:0] rup(logic [15:0] v, logic [15:0] u);
    return (u == 0) ? v : ((v + u - 16'h0001) / u) * u;
  endfunction : rup

  function automatic spc_rsp_s expect_rsp(spc_req_s r);
    spc_rsp_s e;
    e = '0;
    e.pad_width = r.width;
    e.pad_height = r.height;
    if (r.kind == SPC_BUFFER) begin
      e.pad_width = rup(r.width, 16'h0100);
      e.pad_height = 16'h0001;
      e.tail_bytes = 32'h0000_0010;
    end else if (r.kind == SPC_SAMPLED) begin
      e.pad_width = rup(r.width, r.align_i);
      e.pad_height = rup(r.height, r.is_compressed ? 16'h0008 : r.align_j);
      if (r.is_cube) e.pad_height += 16'h0002;
      if (r.is_yuv || r.bytes_per_texel == 5'h0C || r.bytes_per_texel == 5'h06) begin
        e.pad_height += 16'h0001;
        e.tail_bytes = 32'h0000_0010;
      end
    end else begin
      if (r.height[0]) e.pad_height = r.height + 16'h0001;
      if (r.field_mode) e.pad_height = rup(e.pad_height, 16'h0004);
    end
    e.total_bytes = 32'(e.pad_width) * 32'(e.pad_height) *
      32'(r.bytes_per_texel) + e.tail_bytes;
    return e;
  endfunction : expect_rsp

  function automatic spc_req_s mk(spc_kind_e k, logic [15:0] w, logic [15:0] h,
      logic [15:0] i, logic [15:0] j, logic [4:0] b, logic [3:0] f);
    return '{k, w, h, i, j, b, f[3], f[2], f[1], f[0]};
  endfunction : mk

  task automatic step(input logic v, input spc_req_s r);
    logic [3:0] b;
    @(posedge ref_clk);
    {pv, pr, ps, pp} = {req_valid, req, samp_elem, port_elem};
    {psd, ppd} = {samp_data, port_data};
    b = 4'($random(seed));
    req_valid <= v;
    req <= r;
    samp_elem <= '{b[0], mapped, b[1], 16'h0000, 16'h0000};
    port_elem <= '{b[2], mapped, b[3], 16'h0000, 16'h0000};
    samp_data <= $random(seed);
    port_data <= $random(seed);
    #1;
    ex = expect_rsp(pr);
    `CHK(rsp_valid, pv)
    if (pv) begin
      `CHK(rsp.pad_width, ex.pad_width)
      `CHK(rsp.pad_height, ex.pad_height)
      `CHK(rsp.tail_bytes, ex.tail_bytes)
      `CHK(rsp.total_bytes, ex.total_bytes)
      `CHK(rsp.layout_j, pr.is_compressed ? 16'h0004 : pr.align_j)
    end
    `CHK(samp_out_valid, ps.valid & ps.mapped)
    `CHK(samp_xlate_err, ps.valid & ~ps.mapped)
    `CHK(samp_out_data, ps.in_surface ? psd : 32'h0)
    `CHK(port_out_valid, pp.valid & pp.mapped & pp.in_surface)
    `CHK(port_xlate_err, pp.valid & ~pp.mapped)
    `CHK(port_out_data, ppd)
    offset = $unsigned($random(seed)) % (2 * rsp.total_bytes + 32'h2000);
  endtask : step

  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ------------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------------
  initial begin
    #(25ns * 20000);
    num_errors++;
    give_verdict();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {reset, req_valid, req, samp_elem, port_elem} = '1;
    {req_valid, req, samp_elem, port_elem, samp_data, port_data} = '0;
    offset = 32'h0;
    num_errors = 0;
    compares = 0;
    seed = 73;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    step(1, mk(SPC_SAMPLED, 15, 10, 4, 2, 4, 4'h0));
    step(1, mk(SPC_BUFFER, 256, 1, 0, 0, 4, 4'h0));
    step(1, mk(SPC_BUFFER, 257, 1, 0, 0, 4, 4'h0));
    step(1, mk(SPC_SAMPLED, 8, 8, 4, 4, 4, 4'h8));
    step(1, mk(SPC_SAMPLED, 8, 9, 4, 4, 8, 4'h4));
    step(1, mk(SPC_SAMPLED, 8, 8, 4, 4, 12, 4'h0));
    step(1, mk(SPC_SAMPLED, 8, 8, 4, 4, 6, 4'h0));
    step(1, mk(SPC_SAMPLED, 8, 8, 4, 4, 2, 4'h2));
    step(1, mk(SPC_SAMPLED, 7, 9, 4, 4, 8, 4'hE));
    step(1, mk(SPC_RENDER, 8, 5, 0, 0, 4, 4'h0));
    step(1, mk(SPC_RENDER, 8, 5, 0, 0, 4, 4'h1));
    step(1, mk(SPC_RENDER, 8, 8, 0, 0, 4, 4'h1));
    step(0, '0);
    $display("corner cases done");
    repeat (600) begin
      step(1'($random(seed)), mk(spc_kind_e'($unsigned($random(seed)) % 3),
        16'($random(seed)) & 16'h03FF, 16'($random(seed)) & 16'h03FF,
        16'h0001 << ($unsigned($random(seed)) % 4),
        16'h0001 << ($unsigned($random(seed)) % 4),
        5'($unsigned($random(seed)) % 16 + 1), 4'($random(seed))));
    end
    step(0, '0);
    $display("random requests done");
    give_verdict();
  end
endmodule : surface_padding_calc_test
